// File: gpio_port_cfg.svh
// register offsets, field positions, reset values for the port block
`ifndef GPIO_PORT_CFG_SVH
`define GPIO_PORT_CFG_SVH
`define OFS_PIN_VALUE 12'h000
`define OFS_DIRECTION 12'h004
`define OFS_LATCH 12'h008
`define OFS_ANALOG 12'h00c
`define OFS_STEER 12'h010
`define OFS_PERIPH_EN 12'h014
`define OFS_PERIPH_OUT 12'h018
`define RST_DIRECTION 8'hff
`define RST_LATCH 8'h00
`define RST_ANALOG 8'h2f
`define MASK_ANALOG 8'h2f
`define RST_STEER 8'h00
`define MASK_STEER 8'h03
`define BIT_CAPTURE_SEL 0
`define BIT_SELECT_SEL 1
`define PIN_A0 0
`define PIN_A5 5
`define PIN_B3 3
`define PIN_C1 1
`endif

// File: gpio_port_pkg.sv
// types shared by the port block
package gpio_port_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [31:0] word_t;
endpackage

// File: pin_steer.sv
// routes moved functions onto their chosen pins
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_cfg.svh"
module pin_steer
  import gpio_port_pkg::*;
(
  // selections
  input wire logic selectSel,
  input wire logic captureSel,
  // moved function outputs
  input wire logic captureOutEn,
  input wire logic captureOut,
  // pin inputs
  input wire gpio_port_pkg::byte_t portAIn,
  input wire logic pinB3In,
  input wire logic pinC1In,
  // steered results
  output logic selectIn,
  output logic captureIn,
  output logic capOeB3,
  output logic capOeC1,
  output logic capOutB3,
  output logic capOutC1
);
  import gpio_port_pkg::*;
  assign selectIn = selectSel ? portAIn[`PIN_A0] : portAIn[`PIN_A5];
  assign captureIn = captureSel ? pinB3In : pinC1In;
  assign capOeB3 = captureSel & captureOutEn;
  assign capOeC1 = ~captureSel & captureOutEn;
  assign capOutB3 = captureOut;
  assign capOutC1 = captureOut;
endmodule
`default_nettype wire

// File: gpio_port.sv
// eight-bit port with analog select and pin steering, APB slave
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_cfg.svh"
// What this block does
// - eight bits, each input or output
// - direction one disables output driver
// - direction zero drives latch bit
// - pin read gives pins, write hits latch
// - writes are read-modify-write into latch
// - latch write same, latch read latch
// - analog select disables digital input
// - analog pins read zero digitally
// - analog select leaves outputs working
// - analog select resets to analog
// - direction still drives analog pins
// - peripheral owns pin, still readable
// - bit one steers select input
// - bit zero steers capture unit two
// - steering leaves direction bits alone
// - steer bits 7-2 read zero, reset zero
// - highest priority enabled output wins
// - analog only on a0-a3 and a5
// - direction resets to all inputs
module gpio_port
  import gpio_port_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire gpio_port_pkg::word_t pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // port pins
  input wire gpio_port_pkg::byte_t pinIn,
  output gpio_port_pkg::byte_t pinOut,
  output gpio_port_pkg::byte_t pinOe,
  output gpio_port_pkg::byte_t digitalEn,
  // on-chip peripheral override per pin
  input wire gpio_port_pkg::byte_t periphOutEn,
  input wire gpio_port_pkg::byte_t periphOut,
  // second capture unit pins, other ports
  input wire logic captureOutEn,
  input wire logic captureOut,
  input wire logic pinB3In,
  input wire logic pinC1In,
  output logic capOeB3,
  output logic capOeC1,
  output logic capOutB3,
  output logic capOutC1,
  // steered inputs to peripherals
  output logic selectIn,
  output logic captureIn
);
  import gpio_port_pkg::*;

  typedef struct packed {
    byte_t dir;
    byte_t lat;
    byte_t ana;
    byte_t steer;
    byte_t pins;
    word_t rdata;
  } state_s;

  state_s s_q, s_d;

  function automatic logic isOfs(input logic [11:0] a, input logic [11:0] o);
    isOfs = (a == o);
  endfunction

  logic setup;
  logic wr;
  byte_t digIn;
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;

  // input buffer gated by analog select
  assign digitalEn = ~s_q.ana;
  assign digIn = s_q.pins & ~s_q.ana;

  always_comb begin
    s_d = s_q;
    s_d.pins = pinIn;
    if (setup) begin
      s_d.rdata = 32'h0000_0000;
      if (isOfs(paddr, `OFS_PIN_VALUE)) s_d.rdata[7:0] = digIn;
      if (isOfs(paddr, `OFS_DIRECTION)) s_d.rdata[7:0] = s_q.dir;
      if (isOfs(paddr, `OFS_LATCH)) s_d.rdata[7:0] = s_q.lat;
      if (isOfs(paddr, `OFS_ANALOG)) s_d.rdata[7:0] = s_q.ana;
      if (isOfs(paddr, `OFS_STEER)) s_d.rdata[7:0] = s_q.steer;
      if (isOfs(paddr, `OFS_PERIPH_EN)) s_d.rdata[7:0] = periphOutEn;
      if (isOfs(paddr, `OFS_PERIPH_OUT)) s_d.rdata[7:0] = periphOut;
    end
    if (wr) begin
      // port and latch writes store latch
      if (isOfs(paddr, `OFS_PIN_VALUE) || isOfs(paddr, `OFS_LATCH)) begin
        s_d.lat = pwdata[7:0];
      end
      if (isOfs(paddr, `OFS_DIRECTION)) s_d.dir = pwdata[7:0];
      if (isOfs(paddr, `OFS_ANALOG)) s_d.ana = pwdata[7:0] & `MASK_ANALOG;
      if (isOfs(paddr, `OFS_STEER)) s_d.steer = pwdata[7:0] & `MASK_STEER;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q.dir <= `RST_DIRECTION;
      s_q.lat <= `RST_LATCH;
      s_q.ana <= `RST_ANALOG;
      s_q.steer <= `RST_STEER;
      s_q.pins <= 8'h00;
      s_q.rdata <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  // read data is caught at setup so it stands for the whole access;
  // writes wait for the completing edge, so no early side effects
  assign pready = psel & penable;
  assign pslverr = 1'b0;
  assign prdata = s_q.rdata;

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      assign pinOe[i] = periphOutEn[i] | ~s_q.dir[i];
      assign pinOut[i] = periphOutEn[i] ? periphOut[i] : s_q.lat[i];
    end
  endgenerate

  pin_steer u_steer (
    .selectSel(s_q.steer[`BIT_SELECT_SEL]),
    .captureSel(s_q.steer[`BIT_CAPTURE_SEL]),
    .captureOutEn(captureOutEn),
    .captureOut(captureOut),
    .portAIn(digIn),
    .pinB3In(pinB3In),
    .pinC1In(pinC1In),
    .selectIn(selectIn),
    .captureIn(captureIn),
    .capOeB3(capOeB3),
    .capOeC1(capOeC1),
    .capOutB3(capOutB3),
    .capOutC1(capOutC1)
  );

  // a port write lands in the latch
  a_port_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr && paddr == `OFS_PIN_VALUE |=> s_q.lat == $past(pwdata[7:0]))
    else $error("port write did not reach latch");
  a_analog_zero: assert property (@(posedge clk) disable iff (!rst_n)
    setup && paddr == `OFS_PIN_VALUE |=> (prdata[7:0] & s_q.ana) == 8'h00)
    else $error("analog pin read nonzero");
  a_input_hiz: assert property (@(posedge clk) disable iff (!rst_n)
    (s_q.dir[0] && !periphOutEn[0]) |-> !pinOe[0])
    else $error("input pin driven");
  a_output_drive: assert property (@(posedge clk) disable iff (!rst_n)
    (!s_q.dir[1] && !periphOutEn[1]) |-> pinOe[1] && pinOut[1] == s_q.lat[1])
    else $error("output pin not driving latch");
  a_steer_upper: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.steer[7:2] == 6'h00)
    else $error("steer upper bits set");
  a_analog_mask: assert property (@(posedge clk) disable iff (!rst_n)
    (s_q.ana & ~`MASK_ANALOG) == 8'h00)
    else $error("unimplemented analog bit set");
  a_select_route: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.steer[1] |-> selectIn == digIn[0])
    else $error("select input misrouted");
  a_capture_route: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.steer[0] |-> !capOeC1)
    else $error("unselected capture pin driven");
  a_periph_wins: assert property (@(posedge clk) disable iff (!rst_n)
    periphOutEn[2] |-> pinOe[2] && pinOut[2] == periphOut[2])
    else $error("peripheral lost pin");
  a_pin_sample: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> s_q.pins == $past(pinIn))
    else $error("pin sample stale");
  a_dir_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr && paddr == `OFS_DIRECTION |=> s_q.dir == $past(pwdata[7:0]))
    else $error("direction write lost");
  a_latch_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr && paddr == `OFS_LATCH |=> s_q.lat == $past(pwdata[7:0]))
    else $error("latch write lost");
  // analog write keeps only implemented bits
  a_analog_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr && paddr == `OFS_ANALOG |=>
    s_q.ana == ($past(pwdata[7:0]) & `MASK_ANALOG))
    else $error("analog write wrong");
  a_steer_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr && paddr == `OFS_STEER |=> s_q.steer[1:0] == $past(pwdata[1:0]))
    else $error("steer write lost");
  a_steer_keeps: assert property (@(posedge clk) disable iff (!rst_n)
    wr && paddr == `OFS_STEER |=> $stable(s_q.dir))
    else $error("steer write changed direction");
  a_latch_read: assert property (@(posedge clk) disable iff (!rst_n)
    setup && paddr == `OFS_LATCH |=> prdata[7:0] == $past(s_q.lat))
    else $error("latch read wrong");
  a_pin_read: assert property (@(posedge clk) disable iff (!rst_n)
    setup && paddr == `OFS_PIN_VALUE |=> prdata[7:0] == $past(digIn))
    else $error("pin read wrong");
  a_read_upper: assert property (@(posedge clk) disable iff (!rst_n)
    prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_reset_dir: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(rst_n) |-> s_q.dir == `RST_DIRECTION)
    else $error("direction reset wrong");
  a_reset_analog: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(rst_n) |-> s_q.ana == `RST_ANALOG)
    else $error("analog reset wrong");
  a_reset_steer: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(rst_n) |-> s_q.steer == `RST_STEER)
    else $error("steer reset wrong");
  a_digital_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (digitalEn & s_q.ana) == 8'h00)
    else $error("input buffer on for analog pin");
  a_analog_output: assert property (@(posedge clk) disable iff (!rst_n)
    !s_q.dir[3] && s_q.ana[3] && !periphOutEn[3] |-> pinOe[3])
    else $error("analog output not driven");
  a_analog_driver: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.dir[1] && s_q.ana[1] && !periphOutEn[1] |-> !pinOe[1])
    else $error("analog input pin driven");
  a_periph_read: assert property (@(posedge clk) disable iff (!rst_n)
    periphOutEn[5] && !s_q.ana[5] |-> digIn[5] == s_q.pins[5])
    else $error("peripheral pin unreadable");
  // select input on a5 by default
  a_select_a5: assert property (@(posedge clk) disable iff (!rst_n)
    !s_q.steer[1] |-> selectIn == digIn[5])
    else $error("select input not on a5");
  a_capture_b3: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.steer[0] |-> captureIn == pinB3In)
    else $error("capture input not from b3");
  a_capture_c1: assert property (@(posedge clk) disable iff (!rst_n)
    !s_q.steer[0] |-> captureIn == pinC1In)
    else $error("capture input not from c1");
  a_capture_oe: assert property (@(posedge clk) disable iff (!rst_n)
    !s_q.steer[0] |-> !capOeB3 && capOeC1 == captureOutEn)
    else $error("capture drive misrouted to b3");
  a_capture_en: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.steer[0] |-> capOeB3 == captureOutEn)
    else $error("capture drive missing on b3");
  a_port_oe: assert property (@(posedge clk) disable iff (!rst_n)
    (~s_q.dir & ~periphOutEn) == (pinOe & ~periphOutEn))
    else $error("port driver not from direction");
  a_periph_out: assert property (@(posedge clk) disable iff (!rst_n)
    ((pinOut ^ periphOut) & periphOutEn) == 8'h00)
    else $error("peripheral value lost");
  a_latch_out: assert property (@(posedge clk) disable iff (!rst_n)
    ((pinOut ^ s_q.lat) & ~periphOutEn) == 8'h00)
    else $error("latch value not on pin");
  // latch changes only by a write
  a_latch_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !wr |=> $stable(s_q.lat))
    else $error("latch changed without write");
  // direction changes only by a write
  a_dir_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !wr |=> $stable(s_q.dir))
    else $error("direction changed without write");
  // analog select changes only by a write
  a_analog_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !wr |=> $stable(s_q.ana))
    else $error("analog select changed without write");
endmodule
`default_nettype wire

// File: pin_world.sv
// far-side pad model: resolves each pin from device and outside drivers
`timescale 1ns/1ps
`default_nettype none
module pin_world
  import gpio_port_pkg::*;
(
  // device side of the pads
  input wire gpio_port_pkg::byte_t pinOut,
  input wire gpio_port_pkg::byte_t pinOe,
  // outside circuitry, re-drawn by the bench so a floating pad never holds
  input wire gpio_port_pkg::byte_t extVal,
  output gpio_port_pkg::byte_t pinIn
);
  import gpio_port_pkg::*;
  assign pinIn = (pinOut & pinOe) | (extVal & ~pinOe);
endmodule
`default_nettype wire

// File: bidirectional_port_with_pin_steering_bench.sv
// self-checking bench for the eight-bit port block
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_cfg.svh"
module bidirectional_port_with_pin_steering_bench;
  import gpio_port_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  word_t pwdata = '0, prdata, rd;
  logic pready, pslverr, selectIn, captureIn;
  logic capOeB3, capOeC1, capOutB3, capOutC1;
  logic captureOutEn = 0, captureOut = 0, pinB3In = 0, pinC1In = 0;
  byte_t pinIn, pinOut, pinOe, digitalEn, extVal = '0;
  byte_t periphOutEn = '0, periphOut = '0, dir, lat, ana, eo, eu;
  int bad_count = 0, comparisons = 0, cyc = 0;
  always #5 clk = ~clk;
  gpio_port uut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pinIn, .pinOut, .pinOe, .digitalEn,
    .periphOutEn, .periphOut, .captureOutEn, .captureOut, .pinB3In,
    .pinC1In, .capOeB3, .capOeC1, .capOutB3, .capOutC1, .selectIn,
    .captureIn);
  pin_world pads (.pinOut, .pinOe, .extVal, .pinIn);
  task automatic results;
    if (bad_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      bad_count++;
      results();
    end
  end
  task automatic chk(string n, word_t e, word_t s);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, word_t d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rc(string n, logic [11:0] a, word_t e);
    apb(0, a, '0);
    chk(n, e, rd);
  endtask
  initial begin
    void'($urandom(32'h569f));
    repeat (10) @(posedge clk);
    rst_n <= 1;
    rc("dir", `OFS_DIRECTION, 32'hff);
    rc("latch", `OFS_LATCH, 32'h0);
    rc("analog", `OFS_ANALOG, 32'h2f);
    rc("steer", `OFS_STEER, 32'h0);
    chk("oe", 32'h0, pinOe);
    apb(1, `OFS_STEER, 32'hffff_ffff);
    rc("steer", `OFS_STEER, 32'h3);
    apb(1, `OFS_ANALOG, 32'hff);
    rc("analog", `OFS_ANALOG, 32'h2f);
    rc("unmapped", 12'h0fc, 32'h0);
    for (int i = 0; i < 8; i++) begin
      dir = 8'($urandom);
      lat = 8'($urandom);
      ana = 8'($urandom) & 8'h2f;
      @(posedge clk);
      periphOutEn <= 8'($urandom);
      periphOut <= 8'($urandom);
      extVal <= 8'($urandom);
      apb(1, `OFS_DIRECTION, dir);
      apb(1, i[0] ? `OFS_LATCH : `OFS_PIN_VALUE, lat);
      apb(1, `OFS_ANALOG, ana);
      rc("latch", `OFS_LATCH, lat);
      @(negedge clk);
      eo = periphOutEn | ~dir;
      eu = (periphOut & periphOutEn) | (lat & ~periphOutEn);
      chk("oe", eo, pinOe);
      chk("out", eu, pinOut);
      chk("din", 8'(~ana), digitalEn);
      rc("pins", `OFS_PIN_VALUE, ((eo & eu) | (~eo & extVal)) & ~ana);
    end
    // rmw over a driven analog pin drops that bit
    apb(1, `OFS_DIRECTION, 32'h00);
    periphOutEn <= '0;
    apb(1, `OFS_LATCH, 32'hff);
    apb(1, `OFS_ANALOG, 32'h2f);
    apb(0, `OFS_PIN_VALUE, '0);
    apb(1, `OFS_PIN_VALUE, rd | 32'h01);
    rc("rmw", `OFS_LATCH, 32'hd1);
    // a0 high, a5 low so the select route is visible
    dir = 8'hff;
    apb(1, `OFS_DIRECTION, dir);
    extVal <= 8'h01;
    apb(1, `OFS_ANALOG, 32'h0);
    for (int s = 0; s < 4; s++) begin
      apb(1, `OFS_STEER, s);
      @(posedge clk);
      {captureOutEn, captureOut, pinB3In, pinC1In} <= 4'($urandom);
      @(negedge clk);
      chk("capIn", s[0] ? pinB3In : pinC1In, captureIn);
      chk("capOe", {s[0] & captureOutEn, !s[0] & captureOutEn},
        {capOeB3, capOeC1});
      chk("capOut", {2{captureOut}}, {capOutB3, capOutC1});
      chk("sel", s[1] ? pinIn[`PIN_A0] : pinIn[`PIN_A5], selectIn);
    end
    rc("dir", `OFS_DIRECTION, dir);
    results();
  end
endmodule
`default_nettype wire
